// ===== spcu_pkg.sv
// Package: opcodes, lengths, timing and types of the sector protection command unit
package spcu_pkg;

	// Opcodes
	localparam logic [7:0] OP_STAT_RD  = 8'h05;
	localparam logic [7:0] OP_WR_EN    = 8'h06;
	localparam logic [7:0] OP_CLR_STAT = 8'h30;
	localparam logic [7:0] OP_SUSP     = 8'h75;
	localparam logic [7:0] OP_MODE_RD  = 8'h2B;
	localparam logic [7:0] OP_MODE_PG  = 8'h2F;
	localparam logic [7:0] OP_VOL_RD   = 8'hE0;
	localparam logic [7:0] OP_VOL_WR   = 8'hE1;
	localparam logic [7:0] OP_PER_RD   = 8'hE2;
	localparam logic [7:0] OP_PER_PG   = 8'hE3;
	localparam logic [7:0] OP_PER_ER   = 8'hE4;
	localparam logic [7:0] OP_LOCK_RD  = 8'hA7;
	localparam logic [7:0] OP_LOCK_CLR = 8'hA6;
	localparam logic [7:0] OP_PW_RD    = 8'hE7;
	localparam logic [7:0] OP_PW_PG    = 8'hE8;
	localparam logic [7:0] OP_PW_UNL   = 8'hE9;

	// Frame lengths in bits, opcode included
	localparam logic [6:0] LEN_OP      = 7'h08;
	localparam logic [6:0] LEN_ADDR    = 7'h28;
	localparam logic [6:0] LEN_MODE_PG = 7'h18;
	localparam logic [6:0] LEN_VOL_WR  = 7'h30;
	localparam logic [6:0] LEN_PW      = 7'h48;
	localparam logic [6:0] LEN_MAX     = 7'h7F;

	// Register layout and reset values
	localparam int          PW_MODE_BIT = 2;
	localparam int          SR_WIP_BIT  = 0;
	localparam int          SR_WEL_BIT  = 1;
	localparam int          SR_PERR_BIT = 6;
	localparam logic [15:0] MODE_RESET  = 16'hFFFF;
	localparam logic [63:0] PW_RESET    = 64'hFFFF_FFFF_FFFF_FFFF;
	localparam logic [7:0]  BITS_SET    = 8'hFF;
	localparam logic [7:0]  BITS_CLR    = 8'h00;

	// Sector geometry
	localparam int SECTORS_DEF = 256;
	localparam int SECT_SHIFT  = 18;

	// Self-timed operation durations
	localparam int CLK_PERIOD_NS = 10;
	localparam int PROG_TIME_NS  = 2000;
	localparam int ERASE_TIME_NS = 5000;
	localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ERASE_CYCLES  = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Decoded command kinds
	typedef enum logic [4:0] {
		CMD_NONE, CMD_STAT_RD, CMD_WR_EN, CMD_CLR_STAT, CMD_SUSP,
		CMD_MODE_RD, CMD_MODE_PG, CMD_VOL_RD, CMD_VOL_WR, CMD_PER_RD,
		CMD_PER_PG, CMD_PER_ER, CMD_LOCK_RD, CMD_LOCK_CLR, CMD_PW_RD,
		CMD_PW_PG, CMD_PW_UNL
	} spcu_cmd_e;

	// Status bits shown on the status port
	typedef struct packed {
		logic perr;
		logic write_enable_latch;
		logic operation_in_progress;
	} spcu_status_s;

	// Opcode to command kind
	function automatic spcu_cmd_e spcu_decode(input logic [7:0] op);
		case (op)
			OP_STAT_RD:  return CMD_STAT_RD;
			OP_WR_EN:    return CMD_WR_EN;
			OP_CLR_STAT: return CMD_CLR_STAT;
			OP_SUSP:     return CMD_SUSP;
			OP_MODE_RD:  return CMD_MODE_RD;
			OP_MODE_PG:  return CMD_MODE_PG;
			OP_VOL_RD:   return CMD_VOL_RD;
			OP_VOL_WR:   return CMD_VOL_WR;
			OP_PER_RD:   return CMD_PER_RD;
			OP_PER_PG:   return CMD_PER_PG;
			OP_PER_ER:   return CMD_PER_ER;
			OP_LOCK_RD:  return CMD_LOCK_RD;
			OP_LOCK_CLR: return CMD_LOCK_CLR;
			OP_PW_RD:    return CMD_PW_RD;
			OP_PW_PG:    return CMD_PW_PG;
			OP_PW_UNL:   return CMD_PW_UNL;
			default:     return CMD_NONE;
		endcase
	endfunction : spcu_decode

	// Reverse byte order of a 64-bit word
	function automatic logic [63:0] spcu_swap64(input logic [63:0] w);
		logic [63:0] r;
		r = '0;
		for (int i = 0; i < 8; i++) begin
			r[8*i +: 8] = w[8*(7-i) +: 8];
		end
		return r;
	endfunction : spcu_swap64

endpackage : spcu_pkg

// ===== spcu_mem.sv
// Small sector byte memory with registered read data
`timescale 1ns/1ps
module spcu_mem #(
	parameter int W     = 8,
	parameter int DEPTH = 256,
	parameter int AW    = 8
) (
	input  wire logic          sys_clk_in,
	input  wire logic          rst_b_in,
	input  wire logic          we_in,
	input  wire logic [AW-1:0] waddr_in,
	input  wire logic [W-1:0]  wdata_in,
	input  wire logic [AW-1:0] raddr_in,
	output logic      [W-1:0]  rdata_out
);

	logic [W-1:0] mem_q [DEPTH];

	// Array write, no reset on storage
	always_ff @(posedge sys_clk_in) begin
		if (we_in) begin
			mem_q[waddr_in] <= wdata_in;
		end
	end

	// Registered read port
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rdata_out <= '0;
		end else begin
			rdata_out <= mem_q[raddr_in];
		end
	end

endmodule : spcu_mem

// ===== spcu_core.sv
// Serial command unit for sector protection, sampled on the system clock
`timescale 1ns/1ps
module spcu_core #(
	parameter int SECTORS   = spcu_pkg::SECTORS_DEF,
	parameter int PROG_CYC  = spcu_pkg::PROG_CYCLES,
	parameter int ERASE_CYC = spcu_pkg::ERASE_CYCLES
) (
	input  wire logic              sys_clk_in,
	input  wire logic              rst_b_in,
	input  wire logic              cs_b_in,
	input  wire logic              sck_in,
	input  wire logic              si_in,
	output logic                   so_out,
	output logic                   so_oe_out,
	output spcu_pkg::spcu_status_s status_out,
	output logic                   ppb_lock_out,
	output logic [15:0]            mode_out
);

	localparam int SAW = (SECTORS > 1) ? $clog2(SECTORS) : 1;
	localparam logic [SAW-1:0] LAST_SECT = SAW'(SECTORS - 1);

	typedef enum logic [1:0] {ENG_IDLE, ENG_WAIT, ENG_SWEEP} spcu_eng_e;

	// Whole state of the unit
	typedef struct packed {
		logic [2:0]             s1;
		logic [2:0]             s2;
		logic [2:0]             s3;
		logic [2:0]             pin;
		logic [6:0]             bits;
		logic [63:0]            rx;
		spcu_pkg::spcu_cmd_e    cmd;
		logic [SAW-1:0]         sect;
		logic                   rd_phase;
		logic                   loaded;
		logic [63:0]            tx;
		logic                   so;
		logic                   so_oe;
		spcu_pkg::spcu_status_s st;
		logic                   lock;
		logic                   init;
		logic [15:0]            mode;
		logic [63:0]            pw;
		spcu_eng_e              eng;
		spcu_pkg::spcu_cmd_e    op;
		logic [SAW-1:0]         op_sect;
		logic [63:0]            op_data;
		logic [15:0]            tmr;
		logic [SAW-1:0]         swp;
		logic                   pass;
	} spcu_state_s;

	spcu_state_s r_q;
	spcu_state_s r_d;

	logic                vol_we;
	logic                per_we;
	logic [SAW-1:0]      per_waddr;
	logic [7:0]          per_wdata;
	logic [7:0]          vol_rdata;
	logic [7:0]          per_rdata;
	logic                cs_b;
	logic                cs_fall;
	logic                cs_rise;
	logic                sck_rise;
	logic                sck_fall;
	logic [6:0]          nbits;
	logic [63:0]         nrx;
	spcu_pkg::spcu_cmd_e ncmd;
	logic                rd_ok;
	logic [63:0]         word;
	logic [7:0]          sr_byte;

	// Volatile access bytes, one per sector
	spcu_mem #(
		.W     (8),
		.DEPTH (SECTORS),
		.AW    (SAW)
	) u_vol_mem (
		.sys_clk_in (sys_clk_in),
		.rst_b_in   (rst_b_in),
		.we_in      (vol_we),
		.waddr_in   (r_q.op_sect),
		.wdata_in   (r_q.op_data[7:0]),
		.raddr_in   (r_q.sect),
		.rdata_out  (vol_rdata)
	);

	// Persistent access bytes, one per sector
	spcu_mem #(
		.W     (8),
		.DEPTH (SECTORS),
		.AW    (SAW)
	) u_per_mem (
		.sys_clk_in (sys_clk_in),
		.rst_b_in   (rst_b_in),
		.we_in      (per_we),
		.waddr_in   (per_waddr),
		.wdata_in   (per_wdata),
		.raddr_in   (r_q.sect),
		.rdata_out  (per_rdata)
	);

	// Next-state logic
	always_comb begin
		r_d       = r_q;
		vol_we    = 1'b0;
		per_we    = 1'b0;
		per_waddr = r_q.op_sect;
		per_wdata = spcu_pkg::BITS_CLR;
		nbits     = r_q.bits;
		nrx       = r_q.rx;
		ncmd      = r_q.cmd;
		rd_ok     = 1'b0;
		word      = r_q.tx;
		sr_byte   = '0;
		sr_byte[spcu_pkg::SR_WIP_BIT]  = r_q.st.operation_in_progress;
		sr_byte[spcu_pkg::SR_WEL_BIT]  = r_q.st.write_enable_latch;
		sr_byte[spcu_pkg::SR_PERR_BIT] = r_q.st.perr;

		// Three-stage pin sampling, a change counts once stages two and three agree
		r_d.s1 = {cs_b_in, sck_in, si_in};
		r_d.s2 = r_q.s1;
		r_d.s3 = r_q.s2;
		for (int i = 0; i < 3; i++) begin
			if (r_q.s2[i] == r_q.s3[i]) begin
				r_d.pin[i] = r_q.s3[i];
			end
		end
		cs_b     = r_q.pin[2];
		cs_fall  = r_q.pin[2] & ~r_d.pin[2];
		cs_rise  = ~r_q.pin[2] & r_d.pin[2];
		sck_rise = ~r_q.pin[1] & r_d.pin[1] & ~cs_b;
		sck_fall = r_q.pin[1] & ~r_d.pin[1] & ~cs_b;

		// Lock bit takes its power-on value from the mode register once
		if (!r_q.init) begin
			r_d.init = 1'b1;
			r_d.lock = r_q.mode[spcu_pkg::PW_MODE_BIT];
		end

		// Frame start
		if (cs_fall) begin
			r_d.bits     = '0;
			r_d.cmd      = spcu_pkg::CMD_NONE;
			r_d.rd_phase = 1'b0;
			r_d.loaded   = 1'b0;
		end

		// Input shifting on rising clock edges
		if (sck_rise) begin
			nrx = {r_q.rx[62:0], r_q.pin[0]};
			if (r_q.bits != spcu_pkg::LEN_MAX) begin
				nbits = r_q.bits + 7'h01;
			end
			if (nbits == spcu_pkg::LEN_OP) begin
				ncmd = spcu_pkg::spcu_decode(nrx[7:0]);
			end
			r_d.rx   = nrx;
			r_d.bits = nbits;
			r_d.cmd  = ncmd;
			if (nbits == spcu_pkg::LEN_ADDR) begin
				r_d.sect = nrx[spcu_pkg::SECT_SHIFT +: SAW];
			end
			// Decide whether a read phase opens after this bit
			case (ncmd)
				spcu_pkg::CMD_STAT_RD,
				spcu_pkg::CMD_MODE_RD: begin
					rd_ok = (nbits == spcu_pkg::LEN_OP);
				end
				spcu_pkg::CMD_LOCK_RD: begin
					rd_ok = (nbits == spcu_pkg::LEN_OP) && !r_q.st.operation_in_progress;
				end
				spcu_pkg::CMD_PW_RD: begin
					rd_ok = (nbits == spcu_pkg::LEN_OP) && !r_q.st.operation_in_progress
						&& r_q.mode[spcu_pkg::PW_MODE_BIT];
				end
				spcu_pkg::CMD_VOL_RD,
				spcu_pkg::CMD_PER_RD: begin
					rd_ok = (nbits == spcu_pkg::LEN_ADDR) && !r_q.st.operation_in_progress;
				end
				default: begin
					rd_ok = 1'b0;
				end
			endcase
			if (rd_ok) begin
				r_d.rd_phase = 1'b1;
			end
		end

		// Output shifting on falling clock edges, pattern rotates to repeat
		if (sck_fall && r_q.rd_phase) begin
			if (!r_q.loaded) begin
				case (r_q.cmd)
					spcu_pkg::CMD_STAT_RD: word = {8{sr_byte}};
					spcu_pkg::CMD_MODE_RD: word = {4{r_q.mode[7:0], r_q.mode[15:8]}};
					spcu_pkg::CMD_VOL_RD:  word = {8{vol_rdata}};
					spcu_pkg::CMD_PER_RD:  word = {8{per_rdata}};
					spcu_pkg::CMD_LOCK_RD: word = {8{7'h00, r_q.lock}};
					spcu_pkg::CMD_PW_RD:   word = spcu_pkg::spcu_swap64(r_q.pw);
					default:               word = '0;
				endcase
			end
			r_d.so     = word[63];
			r_d.tx     = {word[62:0], word[63]};
			r_d.loaded = 1'b1;
			r_d.so_oe  = 1'b1;
		end

		// Frame end: exact-length write-type commands start here
		if (cs_rise) begin
			r_d.rd_phase = 1'b0;
			r_d.so_oe    = 1'b0;
			if (!r_q.st.operation_in_progress) begin
				case (r_q.cmd)
					spcu_pkg::CMD_WR_EN: begin
						if (r_q.bits == spcu_pkg::LEN_OP) begin
							r_d.st.write_enable_latch = 1'b1;
						end
					end
					spcu_pkg::CMD_CLR_STAT: begin
						if (r_q.bits == spcu_pkg::LEN_OP) begin
							r_d.st.perr = 1'b0;
						end
					end
					spcu_pkg::CMD_MODE_PG: begin
						if (r_q.bits == spcu_pkg::LEN_MODE_PG && r_q.st.write_enable_latch) begin
							r_d.eng = ENG_WAIT;
						end
					end
					spcu_pkg::CMD_VOL_WR: begin
						if (r_q.bits == spcu_pkg::LEN_VOL_WR && r_q.st.write_enable_latch) begin
							r_d.eng = ENG_WAIT;
						end
					end
					spcu_pkg::CMD_PER_PG: begin
						if (r_q.bits == spcu_pkg::LEN_ADDR && r_q.st.write_enable_latch) begin
							r_d.eng = ENG_WAIT;
						end
					end
					spcu_pkg::CMD_PER_ER: begin
						if (r_q.bits == spcu_pkg::LEN_OP && r_q.st.write_enable_latch) begin
							r_d.eng = ENG_WAIT;
						end
					end
					spcu_pkg::CMD_LOCK_CLR: begin
						if (r_q.bits == spcu_pkg::LEN_OP && r_q.st.write_enable_latch) begin
							r_d.eng = ENG_WAIT;
						end
					end
					spcu_pkg::CMD_PW_PG: begin
						if (r_q.bits == spcu_pkg::LEN_PW && r_q.st.write_enable_latch
							&& r_q.mode[spcu_pkg::PW_MODE_BIT]) begin
							r_d.eng = ENG_WAIT;
						end
					end
					spcu_pkg::CMD_PW_UNL: begin
						if (r_q.bits == spcu_pkg::LEN_PW) begin
							r_d.eng = ENG_WAIT;
						end
					end
					default: begin
						r_d.eng = ENG_IDLE;
					end
				endcase
				// Capture operands and raise busy for an accepted operation
				if (r_d.eng == ENG_WAIT) begin
					r_d.st.operation_in_progress = 1'b1;
					r_d.op      = r_q.cmd;
					r_d.op_sect = r_q.sect;
					r_d.op_data = r_q.rx;
					r_d.tmr     = (r_q.cmd == spcu_pkg::CMD_PER_ER) ? 16'(ERASE_CYC)
						: 16'(PROG_CYC);
				end
			end else if (r_q.cmd == spcu_pkg::CMD_CLR_STAT && r_q.bits == spcu_pkg::LEN_OP
				&& r_q.eng == ENG_IDLE) begin
				// Clears a failed operation's held busy and error state
				r_d.st.perr = 1'b0;
				r_d.st.operation_in_progress  = 1'b0;
			end
			// Suspend is not offered; during persistent erase it is refused
			if (r_q.cmd == spcu_pkg::CMD_SUSP && r_q.op == spcu_pkg::CMD_PER_ER) begin
				r_d.eng = r_q.eng;
			end
		end

		// Self-timed operation engine
		case (r_q.eng)
			ENG_IDLE: begin
				r_d.pass = 1'b0;
			end
			ENG_WAIT: begin
				if (r_q.tmr != '0) begin
					r_d.tmr = r_q.tmr - 16'h0001;
				end else begin
					r_d.eng = ENG_IDLE;
					case (r_q.op)
						spcu_pkg::CMD_MODE_PG: begin
							r_d.mode = {r_q.op_data[7:0], r_q.op_data[15:8]};
						end
						spcu_pkg::CMD_VOL_WR: begin
							vol_we = 1'b1;
						end
						spcu_pkg::CMD_PER_PG: begin
							per_we = r_q.lock;
						end
						spcu_pkg::CMD_PER_ER: begin
							if (r_q.lock) begin
								r_d.eng = ENG_SWEEP;
								r_d.swp = '0;
							end
						end
						spcu_pkg::CMD_LOCK_CLR: begin
							r_d.lock = 1'b0;
						end
						spcu_pkg::CMD_PW_PG: begin
							r_d.pw = spcu_pkg::spcu_swap64(r_q.op_data);
						end
						spcu_pkg::CMD_PW_UNL: begin
							if (spcu_pkg::spcu_swap64(r_q.op_data) == r_q.pw) begin
								r_d.lock = 1'b1;
							end
						end
						default: begin
							r_d.lock = r_q.lock;
						end
					endcase
					// Failures hold busy and raise the error bit
					if ((r_q.op == spcu_pkg::CMD_PW_UNL
						&& spcu_pkg::spcu_swap64(r_q.op_data) != r_q.pw)
						|| ((r_q.op == spcu_pkg::CMD_PER_PG || r_q.op == spcu_pkg::CMD_PER_ER)
						&& !r_q.lock)) begin
						r_d.st.perr = 1'b1;
					end else if (r_d.eng == ENG_IDLE) begin
						r_d.st.operation_in_progress = 1'b0;
						r_d.st.write_enable_latch = 1'b0;
					end
				end
			end
			ENG_SWEEP: begin
				// Pass zero preprograms every sector, pass one erases it
				per_we    = 1'b1;
				per_waddr = r_q.swp;
				per_wdata = r_q.pass ? spcu_pkg::BITS_SET : spcu_pkg::BITS_CLR;
				r_d.swp   = r_q.swp + SAW'(1);
				if (r_q.swp == LAST_SECT) begin
					r_d.swp  = '0;
					r_d.pass = 1'b1;
					if (r_q.pass) begin
						r_d.eng    = ENG_IDLE;
						r_d.st.operation_in_progress = 1'b0;
						r_d.st.write_enable_latch = 1'b0;
					end
				end
			end
			default: begin
				r_d.eng = ENG_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			r_q      <= '0;
			r_q.s1   <= 3'h4;
			r_q.s2   <= 3'h4;
			r_q.s3   <= 3'h4;
			r_q.pin  <= 3'h4;
			r_q.mode <= spcu_pkg::MODE_RESET;
			r_q.pw   <= spcu_pkg::PW_RESET;
		end else begin
			r_q <= r_d;
		end
	end

	// Outputs straight from the state register
	assign so_out       = r_q.so;
	assign so_oe_out    = r_q.so_oe;
	assign status_out   = r_q.st;
	assign ppb_lock_out = r_q.lock;
	assign mode_out     = r_q.mode;

endmodule : spcu_core

// ===== spcu_core_sva.sv
// Port-level assertion checker for the sector protection command unit
`timescale 1ns/1ps
module spcu_core_sva (
	input wire logic                   sys_clk_in,
	input wire logic                   rst_b_in,
	input wire logic                   cs_b_in,
	input wire logic                   sck_in,
	input wire logic                   so_out,
	input wire logic                   so_oe_out,
	input wire spcu_pkg::spcu_status_s status_out,
	input wire logic                   ppb_lock_out,
	input wire logic [15:0]            mode_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);
	// A failed operation parked while select stays high
	sequence s_parked;
		(status_out.perr && cs_b_in)[*8];
	endsequence
	// Select has been high for a while
	sequence s_idle_link;
		cs_b_in[*8];
	endsequence
	property p_start;
		$rose(status_out.operation_in_progress) |-> cs_b_in && !$past(cs_b_in, 10);
	endproperty
	property p_perr_busy;
		$rose(status_out.perr) |-> status_out.operation_in_progress;
	endproperty
	property p_perr_hold;
		s_parked |=> status_out.perr;
	endproperty
	property p_wip_hold;
		s_parked |=> status_out.operation_in_progress;
	endproperty
	property p_oe_idle;
		s_idle_link |-> !so_oe_out;
	endproperty
	property p_so_fall;
		so_oe_out && $past(so_oe_out) && $changed(so_out) |-> !sck_in;
	endproperty
	property p_mode_end;
		$changed(mode_out) |-> ##[0:2] !status_out.operation_in_progress;
	endproperty
	property p_lock_clear;
		$fell(ppb_lock_out) |-> ##[0:2] !status_out.operation_in_progress;
	endproperty
	a_start: assert property (p_start) else $error("busy rose outside a frame end");
	a_perr_busy: assert property (p_perr_busy) else $error("error set while idle");
	a_perr_hold: assert property (p_perr_hold) else $error("error dropped by itself");
	a_wip_hold: assert property (p_wip_hold) else $error("busy dropped after error");
	a_oe_idle: assert property (p_oe_idle) else $error("output driven outside frame");
	a_so_fall: assert property (p_so_fall) else $error("output moved while sck high");
	a_mode_end: assert property (p_mode_end) else $error("mode changed mid operation");
	a_lock_clear: assert property (p_lock_clear) else $error("lock fell mid operation");
endmodule : spcu_core_sva

bind spcu_core spcu_core_sva chk_u (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
	.cs_b_in(cs_b_in), .sck_in(sck_in), .so_out(so_out), .so_oe_out(so_oe_out),
	.status_out(status_out), .ppb_lock_out(ppb_lock_out), .mode_out(mode_out));

// ===== spcu_host_model.sv
// Serial host controller model driving command frames
`timescale 1ns/1ps
module spcu_host_model (
	output logic      cs_b_out,
	output logic      sck_out,
	output logic      si_out,
	input  wire logic so_in
);
	// Idle link: select high, clock standing low
	initial begin
		cs_b_out = 1'b1;
		sck_out  = 1'b0;
		si_out   = 1'b0;
	end
	// Exact-length frame, MSB first, then nrx bits read
	task automatic xfer(input logic [127:0] tx, input int ntx, input int nrx,
			output logic [127:0] rx);
		rx = '0;
		cs_b_out = 1'b0;
		#62.5;
		for (int i = ntx - 1; i >= 0; i--) begin
			si_out = tx[i];
			#62.5 sck_out = 1'b1;
			#62.5 sck_out = 1'b0;
		end
		for (int i = 0; i < nrx; i++) begin
			si_out = ~si_out; // Unused input toggles
			#62.5 rx = {rx[126:0], so_in};
			sck_out = 1'b1;
			#62.5 sck_out = 1'b0;
		end
		#62.5 cs_b_out = 1'b1;
		si_out = ~si_out;
		#200;
	endtask : xfer
	// Write enable frame ahead of a write-type command
	task automatic write_enable_cmd();
		logic [127:0] rx;
		xfer(128'h06, 8, 0, rx);
	endtask : write_enable_cmd
endmodule : spcu_host_model

// ===== test_sector_protection_command_unit.sv
// Self-checking bench for the sector protection command unit
`timescale 1ns/1ps
module test_sector_protection_command_unit;
	localparam int SECT = 4;
	logic                   sys_clk_in, rst_b_in, cs_b, sck, si, so_out, so_oe_out, lock, oe_seen;
	logic                   so_line;
	spcu_pkg::spcu_status_s status_out;
	logic [15:0]            mode_out;
	logic [127:0]           rx;
	logic [63:0]            pw;
	logic [7:0]             d;
	int                     errors, num_checks, cycles;

	spcu_core #(.SECTORS(SECT), .PROG_CYC(5), .ERASE_CYC(400)) dut_u (.sys_clk_in(sys_clk_in),
		.rst_b_in(rst_b_in), .cs_b_in(cs_b), .sck_in(sck), .si_in(si), .so_out(so_out),
		.so_oe_out(so_oe_out), .status_out(status_out), .ppb_lock_out(lock),
		.mode_out(mode_out));
	// Released output line shows the inverse of the held bit, so a stale value cannot pass
	assign so_line = so_oe_out ? so_out : ~so_out;
	spcu_host_model host_u (.cs_b_out(cs_b), .sck_out(sck), .si_out(si), .so_in(so_line));

	// Clock generation
	initial begin
		sys_clk_in = 1'b0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end
	// Timeout and output-enable watch
	always @(posedge sys_clk_in) begin
		cycles++;
		if (so_oe_out === 1'b1) oe_seen = 1'b1;
		if (cycles == 60000) begin
			errors++;
			give_verdict();
		end
	end
	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic give_verdict();
		$display("checks=%0d errors=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : give_verdict
	// Poll busy with a bound
	task automatic wait_idle();
		int n;
		n = 0;
		while (status_out.operation_in_progress !== 1'b0 && n < 3000) begin
			@(posedge sys_clk_in);
			n++;
		end
		if (n >= 3000) errors++;
	endtask : wait_idle
	// Sector base address, upper bits zero
	function automatic logic [31:0] addr(input int s);
		return 32'(s) << 18;
	endfunction : addr
	// Password as sent on the wire: low byte first
	function automatic logic [63:0] wire_pw(input logic [63:0] p);
		logic [63:0] r;
		for (int i = 0; i < 8; i++) r[63-8*i -: 8] = p[8*i +: 8];
		return r;
	endfunction : wire_pw

	// Main sequence
	initial begin
		errors = 0;
		num_checks = 0;
		cycles = 0;
		oe_seen = 1'b0;
		rst_b_in = 1'b0;
		pw = {$urandom(11), $urandom()};
		repeat (16) @(posedge sys_clk_in);
		#1 rst_b_in = 1'b1;
		repeat (8) @(posedge sys_clk_in);
		for (int s = 0; s < SECT; s++) begin
			d = 8'($urandom());
			host_u.write_enable_cmd();
			host_u.xfer({8'hE1, addr(s), d}, 48, 0, rx);
			wait_idle();
			check(status_out, 3'b000);
			host_u.xfer({8'hE0, addr(s)}, 40, 16, rx);
			check(rx[15:0], {d, d});
			host_u.xfer({8'hE1, addr(s), ~d}, 48, 0, rx);
			check(status_out, 3'b000);
			host_u.write_enable_cmd();
			host_u.xfer({8'hE1, addr(s), ~d} >> 1, 47, 0, rx);
			check(status_out, 3'b010);
			host_u.xfer({8'hE0, addr(s)}, 40, 8, rx);
			check(rx[7:0], d);
		end
		host_u.write_enable_cmd();
		host_u.xfer(128'hE4, 8, 0, rx);
		check(status_out.operation_in_progress, 1'b1);
		host_u.xfer(128'h75, 8, 0, rx);
		check(status_out.operation_in_progress, 1'b1);
		oe_seen = 1'b0;
		host_u.xfer(128'hA7, 8, 8, rx);
		check(oe_seen, 1'b0);
		wait_idle();
		host_u.write_enable_cmd();
		host_u.xfer({8'hE3, addr(1)}, 40, 0, rx);
		wait_idle();
		check(status_out, 3'b000);
		for (int s = 0; s < SECT; s++) begin
			host_u.xfer({8'hE2, addr(s)}, 40, 16, rx);
			check(rx[15:0], (s == 1) ? 16'h0000 : 16'hFFFF);
		end
		host_u.xfer(128'hA7, 8, 16, rx);
		check(rx[15:0], 16'h0101);
		host_u.write_enable_cmd();
		host_u.xfer(128'hA6, 8, 0, rx);
		wait_idle();
		check({lock, status_out}, 4'b0000);
		host_u.write_enable_cmd();
		host_u.xfer({8'hE3, addr(2)}, 40, 0, rx);
		check({status_out.perr, status_out.operation_in_progress}, 2'b11);
		host_u.xfer(128'h05, 8, 8, rx);
		check(rx[7:0], 8'h43);
		host_u.xfer(128'h30, 8, 0, rx);
		check({status_out.perr, status_out.operation_in_progress}, 2'b00);
		host_u.write_enable_cmd();
		host_u.xfer({8'hE8, wire_pw(pw)}, 72, 0, rx);
		wait_idle();
		host_u.xfer(128'hE7, 8, 128, rx);
		check(rx, {wire_pw(pw), wire_pw(pw)});
		host_u.xfer({8'hE9, wire_pw(~pw)}, 72, 0, rx);
		check({status_out.perr, status_out.operation_in_progress}, 2'b11);
		host_u.xfer(128'hE9, 8, 0, rx);
		check({status_out.perr, status_out.operation_in_progress}, 2'b11);
		host_u.xfer(128'h30, 8, 0, rx);
		check({status_out.perr, status_out.operation_in_progress}, 2'b00);
		host_u.xfer({8'hE9, wire_pw(pw)}, 72, 0, rx);
		wait_idle();
		check({lock, status_out.perr}, 2'b10);
		host_u.write_enable_cmd();
		host_u.xfer({8'h2F, 8'hFB}, 16, 0, rx);
		check(mode_out, 16'hFFFF);
		host_u.xfer({8'h2F, 8'hFB, 8'hFF}, 24, 0, rx);
		wait_idle();
		check(mode_out, 16'hFFFB);
		host_u.xfer(128'h2B, 8, 32, rx);
		check(rx[31:0], 32'hFBFF_FBFF);
		oe_seen = 1'b0;
		host_u.xfer(128'hE7, 8, 8, rx);
		check(oe_seen, 1'b0);
		host_u.write_enable_cmd();
		host_u.xfer({8'hE8, wire_pw(~pw)}, 72, 0, rx);
		check(status_out.operation_in_progress, 1'b0);
		host_u.xfer({8'hE9, wire_pw(pw)}, 72, 0, rx);
		wait_idle();
		check(status_out.perr, 1'b0);
		give_verdict();
	end
endmodule : test_sector_protection_command_unit
